// ---- src/ssp_slave_port.sv ----
// Synchronous serial slave port: registers on sys_clk, shifters on the link clock
`include "ssp_defs.svh"
module ssp_slave_port (
	input wire logic sys_clk,
	input wire logic rstn,
	ssp_link_if.dev link,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rdata,
	output logic wake_req,
	output logic vector_req
);
	ssp_pkg::ssp_dev_sys_t s_q, s_d; // Register-side state
	ssp_pkg::ssp_dev_tx_t t_q, t_d; // Leading-edge link state
	ssp_pkg::ssp_dev_rx_t r_q, r_d; // Trailing-edge link state
	logic slave_on; // Port enabled as clocked slave
	logic tx_mode; // Slave transmit selected
	logic rx_mode; // Slave receive selected
	logic tx_done_ev; // Shift register finished a word
	logic rx_ev; // A full character arrived
	logic pop; // Receive buffer read with data queued
	logic transmit_int_flag; // Transmit buffer empty
	logic receive_int_flag; // Receive queue not empty
	logic [3:0] tx_cur; // Bit driven at this leading edge
	logic [3:0] rx_cur; // Bit sampled at this trailing edge

	// Index of the last bit of the word for the current frame
	function automatic logic [3:0] ssp_last_bit(input logic nine);
		ssp_last_bit = nine ? 4'h8 : 4'h7;
	endfunction : ssp_last_bit

	// Mode decode from the stored control bits
	always_comb begin
		slave_on = s_q.rcsta[`SSP_RC_PORT_ENABLE] & s_q.txsta[`SSP_TX_SYNC]
			& ~s_q.txsta[`SSP_TX_CLOCK_MASTER_SELECT]; // R4
		tx_mode = slave_on & s_q.txsta[`SSP_TX_TRANSMIT_ENABLE] & ~s_q.rcsta[`SSP_RC_CONTINUOUS_RECEIVE_ENABLE]
			& ~s_q.rcsta[`SSP_RC_SINGLE_RECEIVE_ENABLE]; // R6 R7
		// Receiver runs whenever not transmitting; single enable is ignored
		rx_mode = slave_on & ~tx_mode; // R9
	end

	// Register side next state
	always_comb begin
		s_d = s_q;
		s_d.rdata = 8'h00;
		s_d.txd_sync = {s_q.txd_sync[1:0], t_q.done_tgl};
		s_d.rxd_sync = {s_q.rxd_sync[1:0], r_q.tgl};
		tx_done_ev = s_q.txd_sync[2] ^ s_q.txd_sync[1];
		rx_ev = s_q.rxd_sync[2] ^ s_q.rxd_sync[1];
		pop = rd_en & (addr == `SSP_RXBUF_OFS) & (s_q.fifo_cnt != 2'd0);
		// Shift register frees up when the link reports the last bit out
		if (tx_done_ev) begin
			s_d.tsr_busy = 1'b0; // R2
		end
		// Register writes
		if (wr_en) begin
			if (addr == `SSP_TXSTA_OFS) begin
				s_d.txsta = wdata & `SSP_TXSTA_WMASK;
			end else if (addr == `SSP_RCSTA_OFS) begin
				s_d.rcsta = wdata & `SSP_RCSTA_WMASK;
			end else if (addr == `SSP_TXBUF_OFS) begin
				// A write while full is dropped so a queued word is never lost
				if (s_q.txsta[`SSP_TX_TRANSMIT_ENABLE] & ~s_q.txbuf_full) begin
					s_d.txbuf = {s_q.txsta[`SSP_TX_TX9] & s_q.txsta[`SSP_TX_NINTH_TRANSMIT_DATA_BIT], wdata}; // R7 R8
					s_d.txbuf_full = 1'b1;
				end
			end else if (addr == `SSP_PIE_OFS) begin
				s_d.pie = wdata & `SSP_PIE_WMASK;
			end else if (addr == `SSP_BAUDCON_OFS) begin
				s_d.baudcon = wdata;
			end else if (addr == `SSP_BRGL_OFS) begin
				s_d.brgl = wdata;
			end else if (addr == `SSP_BRGH_OFS) begin
				s_d.brgh = wdata;
			end else if (addr == `SSP_INTCTL_OFS) begin
				s_d.intctl = wdata & `SSP_INTCTL_WMASK;
			end
		end
		// Buffered word moves to the shift register as soon as it is free
		if (~s_d.tsr_busy & s_q.txbuf_full) begin
			s_d.tsr_word = s_q.txbuf; // R1 R2
			s_d.tsr_busy = 1'b1;
			s_d.txbuf_full = 1'b0;
		end
		// Read side of the receive queue
		if (pop) begin
			s_d.fifo0 = s_q.fifo1;
			s_d.fifo_cnt = s_q.fifo_cnt - 2'd1;
		end
		// Overrun clears with continuous enable or port enable low
		if (~s_q.rcsta[`SSP_RC_CONTINUOUS_RECEIVE_ENABLE] | ~s_q.rcsta[`SSP_RC_PORT_ENABLE]) begin
			s_d.overrun_flag = 1'b0; // R14
		end
		// A new character: queue it, or flag overrun and drop it
		if (rx_ev & rx_mode) begin
			if (s_q.overrun_flag | (s_d.fifo_cnt == 2'd2)) begin
				s_d.overrun_flag = 1'b1; // R17
			end else begin
				if (s_d.fifo_cnt == 2'd0) begin
					s_d.fifo0 = r_q.word; // R16
				end else begin
					s_d.fifo1 = r_q.word; // R16
				end
				s_d.fifo_cnt = s_d.fifo_cnt + 2'd1; // R12
			end
		end
		// Port enable low empties the transmit buffer, shift register and receive queue and clears overrun
		if (~s_d.rcsta[`SSP_RC_PORT_ENABLE]) begin
			s_d.txbuf_full = 1'b0; // R14
			s_d.tsr_busy = 1'b0;
			s_d.fifo_cnt = 2'd0;
			s_d.overrun_flag = 1'b0;
		end
		// Register reads, data stands in the next cycle only
		if (rd_en) begin
			if (addr == `SSP_TXSTA_OFS) begin
				s_d.rdata = s_q.txsta;
				s_d.rdata[`SSP_TX_TRMT] = ~s_q.tsr_busy;
			end else if (addr == `SSP_RCSTA_OFS) begin
				s_d.rdata = s_q.rcsta;
				s_d.rdata[`SSP_RC_OVERRUN_FLAG] = s_q.overrun_flag;
				// Ninth bit of the top entry; must be read before the low byte
				s_d.rdata[`SSP_RC_NINTH_RECEIVE_DATA_BIT] = s_q.fifo0[8] & s_q.rcsta[`SSP_RC_RX9]; // R13
			end else if (addr == `SSP_RXBUF_OFS) begin
				s_d.rdata = s_q.fifo0[7:0]; // R13
			end else if (addr == `SSP_PIE_OFS) begin
				s_d.rdata = s_q.pie;
			end else if (addr == `SSP_PIR_OFS) begin
				s_d.rdata[`SSP_PI_TXI] = ~s_q.txbuf_full;
				s_d.rdata[`SSP_PI_RCI] = s_q.fifo_cnt != 2'd0;
			end else if (addr == `SSP_BAUDCON_OFS) begin
				s_d.rdata = s_q.baudcon;
			end else if (addr == `SSP_BRGL_OFS) begin
				s_d.rdata = s_q.brgl;
			end else if (addr == `SSP_BRGH_OFS) begin
				s_d.rdata = s_q.brgh;
			end else if (addr == `SSP_INTCTL_OFS) begin
				s_d.rdata = s_q.intctl;
			end
		end
		// Flags as levels; wake needs the peripheral enable as well
		transmit_int_flag = ~s_d.txbuf_full; // R2
		receive_int_flag = s_d.fifo_cnt != 2'd0; // R12
		s_d.wake = s_d.intctl[`SSP_IC_PEIE]
			& ((s_d.pie[`SSP_PI_TXI] & transmit_int_flag & s_d.txsta[`SSP_TX_TRANSMIT_ENABLE]) // R3
			| (s_d.pie[`SSP_PI_RCI] & receive_int_flag)); // R11 R12
		s_d.vector = s_d.wake & s_d.intctl[`SSP_IC_GIE]; // R3 R11
	end

	// Register side flops
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Leading edge: drive the next bit; runs only while the master clocks,
	// which is why it keeps working while the core sleeps
	// The mode is read straight from the register side: the link clock runs
	// only inside frames, so a two-edge synchroniser would swallow two bits.
	// Setup must therefore be finished before the master starts clocking.
	always_comb begin
		t_d = t_q;
		t_d.en_sync = {t_q.en_sync[0], tx_mode};
		// First edge after the mode came on always starts at bit 0
		tx_cur = t_q.en_sync[0] ? t_q.bit_idx : 4'h0;
		if (!tx_mode) begin
			t_d.bit_idx = 4'h0;
			t_d.dout = 1'b1;
		end else begin
			// Word register is held still by the handshake while bits go out
			t_d.dout = s_q.tsr_word[tx_cur]; // R15 R18
			if (tx_cur == ssp_last_bit(s_q.txsta[`SSP_TX_TX9])) begin
				t_d.bit_idx = 4'h0;
				t_d.done_tgl = ~t_q.done_tgl; // R1 R2
			end else begin
				t_d.bit_idx = tx_cur + 4'h1; // R15
			end
		end
	end

	// Leading-edge flops
	always_ff @(posedge link.ser_ck or negedge rstn) begin
		if (!rstn) begin
			t_q <= '0;
		end else begin
			t_q <= t_d;
		end
	end

	// Trailing edge: sample the data wire into the shift register
	always_comb begin
		r_d = r_q;
		r_d.en_sync = {r_q.en_sync[0], rx_mode};
		// Same direct mode read as the transmit side, for the same reason
		rx_cur = r_q.en_sync[0] ? r_q.bit_idx : 4'h0;
		if (!rx_mode) begin
			r_d.bit_idx = 4'h0;
		end else begin
			r_d.receive_shift_register[rx_cur] = link.dt_level; // R16 R18 R10
			if (rx_cur == ssp_last_bit(s_q.rcsta[`SSP_RC_RX9])) begin
				r_d.bit_idx = 4'h0;
				r_d.word = r_d.receive_shift_register;
				if (!s_q.rcsta[`SSP_RC_RX9]) begin
					r_d.word[8] = 1'b0;
				end
				r_d.tgl = ~r_q.tgl; // R10
			end else begin
				r_d.bit_idx = rx_cur + 4'h1;
			end
		end
	end

	// Trailing-edge flops
	always_ff @(negedge link.ser_ck or negedge rstn) begin
		if (!rstn) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	// Outputs
	assign link.dt_s_o = t_q.dout;
	assign link.dt_s_oe = tx_mode; // R15
	assign rdata = s_q.rdata;
	assign wake_req = s_q.wake;
	assign vector_req = s_q.vector;
endmodule : ssp_slave_port

// ---- src/ssp_defs.svh ----
// Constants for the synchronous serial slave port and its clocking master
// What this block does
// R1: Two queued words: first shifts, second waits buffered
// R2: Transmit flag set when second word loads
// R3: Transmit flag with enables requests wake-up, vector
// R4: Software selects slave: clocked mode, enable, no master
// R5: Software sets both pins to input direction
// R6: Transmit needs both receive enables cleared
// R7: Transmit starts on low byte write, enable set
// R8: Ninth transmit bit set before low byte write
// R9: Slave receive never idle, single enable ignored
// R10: Receive continues on external clock during sleep
// R11: Completed character with enable requests wake-up
// R12: Receive flag set when character completes
// R13: Ninth received bit read before low byte
// R14: Overrun cleared by continuous enable or port enable
// R15: Data changes on leading edge, one bit per clock
// R16: Sample on trailing edge, two-deep receive queue
// R17: Third character sets overrun, keeps queue, blocks
// R18: Words shift least significant bit first
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH

// Register offsets on the plain register port
`define SSP_TXSTA_OFS 4'h0
`define SSP_RCSTA_OFS 4'h1
`define SSP_TXBUF_OFS 4'h2
`define SSP_RXBUF_OFS 4'h3
`define SSP_PIE_OFS 4'h4
`define SSP_PIR_OFS 4'h5
`define SSP_BAUDCON_OFS 4'h6
`define SSP_BRGL_OFS 4'h7
`define SSP_BRGH_OFS 4'h8
`define SSP_INTCTL_OFS 4'h9

// Transmit status and control fields
`define SSP_TX_CLOCK_MASTER_SELECT 7
`define SSP_TX_TX9 6
`define SSP_TX_TRANSMIT_ENABLE 5
`define SSP_TX_SYNC 4
`define SSP_TX_TRMT 1
`define SSP_TX_NINTH_TRANSMIT_DATA_BIT 0
`define SSP_TXSTA_WMASK 8'hf1

// Receive status and control fields
`define SSP_RC_PORT_ENABLE 7
`define SSP_RC_RX9 6
`define SSP_RC_SINGLE_RECEIVE_ENABLE 5
`define SSP_RC_CONTINUOUS_RECEIVE_ENABLE 4
`define SSP_RC_OVERRUN_FLAG 1
`define SSP_RC_NINTH_RECEIVE_DATA_BIT 0
`define SSP_RCSTA_WMASK 8'hf0

// Interrupt enable and flag fields
`define SSP_PI_RCI 5
`define SSP_PI_TXI 4
`define SSP_PIE_WMASK 8'h30
`define SSP_IC_GIE 7
`define SSP_IC_PEIE 6
`define SSP_INTCTL_WMASK 8'hc0

// Reset values
`define SSP_REG_RST 8'h00
`define SSP_WORD_IDLE 9'h1ff

// Master clock timing, in ns and in sys_clk cycles at 20 MHz
`define SSP_SYS_NS 50
`define SSP_HALF_NS 200
`define SSP_GAP_NS 400
`define SSP_HALF_CYC (`SSP_HALF_NS / `SSP_SYS_NS)
`define SSP_GAP_CYC (`SSP_GAP_NS / `SSP_SYS_NS)

`endif

// ---- src/ssp_pkg.sv ----
// Types shared by both ends of the synchronous serial port
package ssp_pkg;
	// Master sequencer states
	typedef enum logic [1:0] {
		SSP_IDLE,
		SSP_LOW,
		SSP_HIGH,
		SSP_GAP
	} ssp_mst_state_t;

	// Device register-side state
	typedef struct packed {
		logic [7:0] txsta;
		logic [7:0] rcsta;
		logic [7:0] pie;
		logic [7:0] intctl;
		logic [7:0] baudcon;
		logic [7:0] brgl;
		logic [7:0] brgh;
		logic [8:0] txbuf;
		logic txbuf_full;
		logic [8:0] tsr_word;
		logic tsr_busy;
		logic [8:0] fifo0;
		logic [8:0] fifo1;
		logic [1:0] fifo_cnt;
		logic overrun_flag;
		logic [2:0] txd_sync;
		logic [2:0] rxd_sync;
		logic [7:0] rdata;
		logic wake;
		logic vector;
	} ssp_dev_sys_t;

	// Device transmit side, leading edge of the link clock
	typedef struct packed {
		logic [1:0] en_sync;
		logic [3:0] bit_idx;
		logic dout;
		logic done_tgl;
	} ssp_dev_tx_t;

	// Device receive side, trailing edge of the link clock
	typedef struct packed {
		logic [1:0] en_sync;
		logic [3:0] bit_idx;
		logic [8:0] receive_shift_register;
		logic [8:0] word;
		logic tgl;
	} ssp_dev_rx_t;

	// Master state
	typedef struct packed {
		ssp_mst_state_t st;
		logic [3:0] cnt;
		logic [3:0] bit_idx;
		logic nine;
		logic drive;
		logic [8:0] shtx;
		logic [8:0] rxw;
		logic ck;
		logic dout;
		logic [1:0] din_sync;
		logic done;
		logic [8:0] rx_word;
	} ssp_mst_t;
endpackage : ssp_pkg

// ---- src/ssp_link_if.sv ----
// Link wires between the clocking master and the slave port
interface ssp_link_if;
	logic ser_ck; // Shift clock, made by the master only
	logic dt_m_o; // Master data out
	logic dt_m_oe; // Master drives data
	logic dt_s_o; // Slave data out
	logic dt_s_oe; // Slave drives data
	logic dt_level; // Resolved data wire, pulled high when undriven

	// Wire resolution; slave wins only if both drive, which is a misuse
	assign dt_level = dt_s_oe ? dt_s_o : (dt_m_oe ? dt_m_o : 1'b1);

	modport dev (
		input ser_ck,
		input dt_level,
		output dt_s_o,
		output dt_s_oe
	);
	modport mst (
		output ser_ck,
		output dt_m_o,
		output dt_m_oe,
		input dt_level
	);
endinterface : ssp_link_if

// ---- src/ssp_clock_master.sv ----
// Clocking master: makes the shift clock and exchanges one word per start
`include "ssp_defs.svh"
module ssp_clock_master (
	input wire logic sys_clk,
	input wire logic rstn,
	ssp_link_if.mst link,
	input wire logic start,
	input wire logic send_en,
	input wire logic nine_bit,
	input wire logic [8:0] tx_word,
	output logic [8:0] rx_word,
	output logic done,
	output logic busy
);
	localparam logic [3:0] HALF_CNT = 4'(`SSP_HALF_CYC - 1); // Cycles per clock half
	localparam logic [3:0] GAP_CNT = 4'(`SSP_GAP_CYC - 1); // Quiet time between frames

	ssp_pkg::ssp_mst_t m_q, m_d; // All master state

	// Sequencer: low half, leading edge, high half, trailing edge
	always_comb begin
		m_d = m_q;
		m_d.done = 1'b0;
		m_d.din_sync = {m_q.din_sync[0], link.dt_level};
		case (m_q.st)
			ssp_pkg::SSP_IDLE: begin
				m_d.drive = 1'b0;
				if (start) begin
					m_d.st = ssp_pkg::SSP_LOW;
					m_d.cnt = 4'h0;
					m_d.bit_idx = 4'h0;
					m_d.nine = nine_bit;
					m_d.drive = send_en;
					m_d.shtx = tx_word;
				end
			end
			ssp_pkg::SSP_LOW: begin
				m_d.cnt = m_q.cnt + 4'h1;
				if (m_q.cnt == HALF_CNT) begin
					// Leading edge: our data changes with the clock rise
					m_d.ck = 1'b1; // R15
					m_d.dout = m_q.shtx[m_q.bit_idx]; // R18
					m_d.cnt = 4'h0;
					m_d.st = ssp_pkg::SSP_HIGH;
				end
			end
			ssp_pkg::SSP_HIGH: begin
				m_d.cnt = m_q.cnt + 4'h1;
				if (m_q.cnt == HALF_CNT) begin
					// Trailing edge: slave data has settled through the synchroniser
					m_d.ck = 1'b0;
					m_d.rxw[m_q.bit_idx] = m_q.din_sync[1]; // R16
					m_d.cnt = 4'h0;
					if (m_q.bit_idx == (m_q.nine ? 4'h8 : 4'h7)) begin
						m_d.st = ssp_pkg::SSP_GAP; // R15
					end else begin
						m_d.bit_idx = m_q.bit_idx + 4'h1;
						m_d.st = ssp_pkg::SSP_LOW;
					end
				end
			end
			ssp_pkg::SSP_GAP: begin
				m_d.cnt = m_q.cnt + 4'h1;
				// The gap lets the slave reload its shift word between frames
				if (m_q.cnt == GAP_CNT) begin
					m_d.st = ssp_pkg::SSP_IDLE;
					m_d.drive = 1'b0;
					m_d.done = 1'b1;
					m_d.rx_word = m_q.nine ? m_q.rxw : {1'b0, m_q.rxw[7:0]};
				end
			end
			default: begin
				m_d.st = ssp_pkg::SSP_IDLE;
			end
		endcase
	end

	// State flops
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			m_q <= '0;
		end else begin
			m_q <= m_d;
		end
	end

	assign link.ser_ck = m_q.ck;
	assign link.dt_m_o = m_q.dout;
	assign link.dt_m_oe = m_q.drive;
	assign rx_word = m_q.rx_word;
	assign done = m_q.done;
	assign busy = m_q.st != ssp_pkg::SSP_IDLE;
endmodule : ssp_clock_master

// ---- testbench/ssp_link_checker.sv ----
// Timing checks on the link wires between the clocking master and the slave port
module ssp_link_checker (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic ser_ck,
	input wire logic dt_m_o,
	input wire logic dt_m_oe,
	input wire logic dt_s_o,
	input wire logic dt_s_oe,
	input wire logic dt_level
);
	timeunit 1ns;
	timeprecision 1ps;
	// The link clock is made from sys_clk, so everything is sampled there
	default clocking ck_def @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);
	logic ck_q; // Link clock one cycle back
	logic [3:0] rise_q; // Clock rises in the current frame
	logic [3:0] low_q; // Low samples in a row, saturating
	// A low run longer than a half period closes the frame
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ck_q <= 1'b0;
			rise_q <= 4'h0;
			low_q <= 4'h0;
		end else begin
			ck_q <= ser_ck;
			low_q <= ser_ck ? 4'h0 : (low_q == 4'hf ? low_q : low_q + 4'h1);
			if (ser_ck && !ck_q) begin
				rise_q <= rise_q + 4'h1;
			end else if (low_q == 4'h6) begin
				rise_q <= 4'h0;
			end
		end
	end
	sequence s_high;
		ser_ck [*4] ##1 !ser_ck;
	endsequence
	sequence s_low;
		!ser_ck [*4];
	endsequence
	sequence s_gap;
		$fell(ser_ck) ##4 !ser_ck;
	endsequence
	a_ck_high_half: assert property ($rose(ser_ck) |-> s_high)
		else $error("link clock high phase is not four cycles");
	a_ck_low_half: assert property ($fell(ser_ck) |-> s_low)
		else $error("link clock low phase shorter than four cycles");
	a_frame_gap: assert property (s_gap |=> s_low)
		else $error("link clock gap between frames too short");
	a_slave_hold: assert property ($rose(ser_ck) |=> $stable(dt_s_o) [*7])
		else $error("slave data moved before the next leading edge");
	a_slave_edge: assert property (dt_s_oe && $changed(dt_s_o) |-> $rose(ser_ck))
		else $error("slave data changed away from a leading edge");
	a_master_hold: assert property ($rose(ser_ck) && dt_m_oe |=> $stable(dt_m_o) [*3])
		else $error("master data not held through the trailing edge");
	a_frame_bits: assert property (low_q == 4'h5 && rise_q != 4'h0 |-> rise_q inside {4'h8, 4'h9})
		else $error("frame clock count is neither eight nor nine");
	a_one_driver: assert property (dt_s_oe |-> !dt_m_oe)
		else $error("both ends drive the data wire");
endmodule : ssp_link_checker

// ---- testbench/sync_serial_slave_port_tb.sv ----
// Self-checking bench: slave port and clocking master joined by the link
`include "ssp_defs.svh"
module sync_serial_slave_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// Expected result; an empty name means the result is not compared
	typedef struct {
		string nm;
		logic nine;
		logic [8:0] v;
	} ssp_exp_t;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [7:0] rdata;
	logic wake_req;
	logic vector_req;
	logic start = 1'b0;
	logic send_en = 1'b0;
	logic nine_bit = 1'b0;
	logic [8:0] tx_word = 9'h000;
	logic [8:0] rx_word;
	logic done;
	logic busy;
	logic rd_p = 1'b0; // Read strobe one cycle back
	logic [8:0] wire_sh = 9'h000; // Data wire taken at trailing edges
	int fail_count = 0;
	int total_checks = 0;
	int seed = 32'h94f36f1a;
	ssp_exp_t rd_q[$]; // Pending register reads
	ssp_exp_t fr_q[$]; // Pending master frames
	logic [8:0] w[6]; // Random data words
	logic [3:0] ra[9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'hf};
	ssp_link_if link ();
	ssp_slave_port ssp_slave_port_i (.sys_clk(sys_clk), .rstn(rstn), .link(link), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .wake_req(wake_req),
		.vector_req(vector_req));
	ssp_clock_master ssp_clock_master_i (.sys_clk(sys_clk), .rstn(rstn), .link(link),
		.start(start), .send_en(send_en), .nine_bit(nine_bit), .tx_word(tx_word),
		.rx_word(rx_word), .done(done), .busy(busy));
	ssp_link_checker ssp_link_checker_i (.sys_clk(sys_clk), .rstn(rstn), .ser_ck(link.ser_ck),
		.dt_m_o(link.dt_m_o), .dt_m_oe(link.dt_m_oe), .dt_s_o(link.dt_s_o),
		.dt_s_oe(link.dt_s_oe), .dt_level(link.dt_level));
	// System clock, 50 ns
	initial begin
		forever #25 sys_clk = ~sys_clk;
	end
	// Wire bits arrive least significant first, so shift in from the top
	always @(negedge link.ser_ck) begin
		wire_sh <= {link.dt_level, wire_sh[8:1]};
	end
	task automatic check(input string nm, input logic [8:0] seen, input logic [8:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	// Result watcher: read data the cycle after the strobe, words at done
	always @(posedge sys_clk) begin : watch
		ssp_exp_t e;
		rd_p <= rd_en;
		if (rd_p) begin
			e = rd_q.pop_front();
			if (e.nm != "") check(e.nm, {1'b0, rdata}, e.v);
		end
		if (done === 1'b1) begin
			e = fr_q.pop_front();
			if (e.nm != "") check(e.nm, e.nine ? rx_word : {1'b0, rx_word[7:0]}, e.v);
		end
	end
	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge sys_clk);
		wr_en <= 1'b0;
	endtask : reg_wr
	task automatic reg_rd(input logic [3:0] a, input logic [7:0] e, input string nm);
		rd_q.push_back('{nm, 1'b0, {1'b0, e}});
		@(posedge sys_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge sys_clk);
		rd_en <= 1'b0;
	endtask : reg_rd
	// Settled wake and vector levels
	task automatic lvl(input logic wk, input logic vc);
		repeat (3) @(posedge sys_clk);
		check("wake", {8'h00, wake_req}, {8'h00, wk});
		check("vector", {8'h00, vector_req}, {8'h00, vc});
	endtask : lvl
	// One master frame; the wire copy is compared as well as the master word
	task automatic frame(input logic se, input logic nn, input logic [8:0] tw,
		input logic [8:0] ex, input string nm);
		int n;
		n = 0;
		fr_q.push_back('{nm, nn, ex});
		@(posedge sys_clk);
		start <= 1'b1;
		send_en <= se;
		nine_bit <= nn;
		tx_word <= tw;
		@(posedge sys_clk);
		start <= 1'b0;
		do begin
			@(posedge sys_clk);
			n++;
			if (n == 1) check("busy", {8'h00, busy}, 9'h001);
		end while (done !== 1'b1 && n < 300);
		if (n >= 300) fail_count++;
		check("idle", {8'h00, busy}, 9'h000);
		if (nm != "") check({nm, "_wire"}, nn ? wire_sh : {1'b0, wire_sh[8:1]}, ex);
		repeat (4) @(posedge sys_clk);
	endtask : frame
	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : summarize
	// Hang guard, far beyond the thirteen frames of the run
	initial begin
		repeat (20000) @(posedge sys_clk);
		fail_count++;
		summarize();
	end
	initial begin
		repeat (10) @(posedge sys_clk);
		rstn <= 1'b1;
		for (int i = 0; i < 6; i++) w[i] = 9'($random(seed));
		foreach (ra[i]) reg_rd(ra[i], 8'h00, "reset");
		reg_rd(`SSP_PIR_OFS, 8'h10, "pir_reset");
		reg_rd(`SSP_TXSTA_OFS, 8'h02, "txsta_reset");
		reg_wr(`SSP_BRGL_OFS, w[5][7:0]);
		reg_wr(`SSP_PIE_OFS, 8'hff);
		reg_wr(4'hf, 8'hff);
		reg_rd(`SSP_BRGL_OFS, w[5][7:0], "brg_low");
		reg_rd(`SSP_PIE_OFS, 8'h30, "pie_mask");
		reg_rd(4'hf, 8'h00, "unmapped");
		$display("test registers done");
		// Slave transmit: two words queued, the second waits for the first
		reg_wr(`SSP_INTCTL_OFS, 8'hc0);
		reg_wr(`SSP_PIE_OFS, 8'h10);
		reg_wr(`SSP_TXSTA_OFS, 8'h30);
		reg_wr(`SSP_RCSTA_OFS, 8'h80);
		frame(1'b0, 1'b0, 9'h000, 9'h000, "");
		reg_wr(`SSP_TXBUF_OFS, w[0][7:0]);
		reg_wr(`SSP_TXBUF_OFS, w[1][7:0]);
		reg_rd(`SSP_PIR_OFS, 8'h00, "pir_full");
		reg_rd(`SSP_TXSTA_OFS, 8'h30, "txsta_busy");
		lvl(1'b0, 1'b0);
		frame(1'b0, 1'b0, 9'h000, {1'b0, w[0][7:0]}, "tx_first");
		reg_rd(`SSP_PIR_OFS, 8'h10, "pir_loaded");
		lvl(1'b1, 1'b1);
		frame(1'b0, 1'b0, 9'h000, {1'b0, w[1][7:0]}, "tx_second");
		reg_wr(`SSP_TXSTA_OFS, 8'h71);
		reg_wr(`SSP_TXBUF_OFS, w[2][7:0]);
		frame(1'b0, 1'b1, 9'h000, {1'b1, w[2][7:0]}, "tx_nine");
		reg_wr(`SSP_INTCTL_OFS, 8'h40);
		lvl(1'b1, 1'b0);
		reg_wr(`SSP_TXSTA_OFS, 8'h10);
		reg_wr(`SSP_TXBUF_OFS, w[3][7:0]);
		reg_rd(`SSP_PIR_OFS, 8'h10, "pir_txoff");
		$display("test transmit done");
		// Slave receive: nine bits, overrun on a full queue, then recovery
		reg_wr(`SSP_PIE_OFS, 8'h20);
		reg_wr(`SSP_INTCTL_OFS, 8'hc0);
		reg_wr(`SSP_RCSTA_OFS, 8'hf0);
		frame(1'b1, 1'b1, w[5], w[5], "");
		reg_rd(`SSP_RXBUF_OFS, 8'h00, "");
		reg_rd(`SSP_RXBUF_OFS, 8'h00, "");
		lvl(1'b0, 1'b0);
		for (int i = 0; i < 4; i++) begin
			frame(1'b1, 1'b1, w[i], w[i], "rx_echo");
			if (i == 0) reg_rd(`SSP_PIR_OFS, 8'h30, "pir_rx");
			if (i == 0) lvl(1'b1, 1'b1);
		end
		reg_rd(`SSP_RCSTA_OFS, {7'h79, w[0][8]}, "rcsta_ovr");
		reg_wr(`SSP_RCSTA_OFS, 8'he0);
		reg_rd(`SSP_RCSTA_OFS, {7'h70, w[0][8]}, "rcsta_clr");
		reg_rd(`SSP_RXBUF_OFS, w[0][7:0], "rx_first");
		reg_rd(`SSP_RXBUF_OFS, w[1][7:0], "rx_second");
		reg_rd(`SSP_PIR_OFS, 8'h10, "pir_drained");
		reg_wr(`SSP_RCSTA_OFS, 8'h90);
		frame(1'b1, 1'b0, w[4], {1'b0, w[4][7:0]}, "rx_eight");
		reg_rd(`SSP_RCSTA_OFS, 8'h90, "rcsta_eight");
		reg_rd(`SSP_RXBUF_OFS, w[4][7:0], "rx_after");
		for (int i = 0; i < 3; i++) frame(1'b1, 1'b0, w[i], {1'b0, w[i][7:0]}, "rx_fill");
		reg_wr(`SSP_RCSTA_OFS, 8'h00);
		reg_rd(`SSP_RCSTA_OFS, 8'h00, "rcsta_off");
		reg_rd(`SSP_PIR_OFS, 8'h10, "pir_off");
		$display("test receive done");
		repeat (4) @(posedge sys_clk);
		summarize();
	end
endmodule : sync_serial_slave_port_tb
